// file: keypad_matrix_scanner_test.sv
`timescale 1ns/1ps
module keypad_matrix_scanner_test;
    ////////////////////////////////////////////////////////////////////////////////
    // Signals
    localparam int unsigned DB_CYC = 4;  // Short debounce
    logic       core_clk_i;  // Core clock
    logic       reset_n_i;   // Sync reset
    logic       scan_req;    // One-pass request
    logic       char_req;    // Translated read request
    logic       press;       // Key held
    logic [7:0] key;         // Held key position
    logic [7:0] port;        // Column select
    logic [3:0] rows;        // Row lines
    logic       busy;        // Scanner busy
    logic       kv;          // Key pulse
    logic       nk;          // No-key pulse
    logic [7:0] code;        // Column-row code
    logic [4:0] val;         // Translated value
    logic [7:0] pos [24];    // Key position by value
    int         error_cnt;   // Mismatches
    int         n_tests;     // Comparisons
    int         cyc;         // Cycle count
    kms_scanner #(.DEBOUNCE_CYC(DB_CYC)) uut (
        .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .port_o(port), .rows_i(rows),
        .scan_for_key_i(scan_req), .read_translated_key_i(char_req), .busy_o(busy),
        .key_valid_o(kv), .no_key_o(nk), .key_code_o(code), .key_value_o(val));
    kms_keypad_model u_pad (.port_i(port), .press_i(press), .key_i(key), .rows_o(rows));
    ////////////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic check(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : check
    // One-cycle request, taken while idle
    task automatic req(input logic chr);
        scan_req = !chr;
        char_req = chr;
        @(negedge core_clk_i);
        scan_req = 1'b0;
        char_req = 1'b0;
    endtask : req
    // Bounded wait for either result pulse
    task automatic wait_res(input int lim);
        int i;
        for (i = 0; i < lim && kv !== 1'b1 && nk !== 1'b1; i++) @(negedge core_clk_i);
        if (i == lim) check("result wait", 8'h01, 8'h00);
    endtask : wait_res
    // Hold a key, then release and wait for the report
    task automatic press_key(input logic [7:0] k);
        key = k;
        press = 1'b1;
        repeat (40) @(negedge core_clk_i);
        check("held no report", 8'h01, {7'h0, busy & !kv});
        press = 1'b0;
        wait_res(100);
        check("key pulse", 8'h01, {7'h0, kv});
    endtask : press_key
    task automatic results();
        $display("Summary: %0d checks, %0d mismatches", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : results
    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset();
        check("port", 8'h00, port);
        check("busy", 8'h00, {7'h0, busy});
        check("code", kms_pkg::NO_CODE, code);
        check("value", {3'h0, kms_pkg::NO_VALUE}, {3'h0, val});
        $display("test reset done");
    endtask : t_reset
    // Empty pass over six columns
    task automatic t_nokey();
        req(1'b0);
        check("busy", 8'h01, {7'h0, busy});
        wait_res(60);
        check("no key", 8'h01, {7'h0, nk});
        check("code", kms_pkg::NO_CODE, code);
        check("value", {3'h0, kms_pkg::NO_VALUE}, {3'h0, val});
        $display("test nokey done");
    endtask : t_nokey
    // Every key back to back, then a two-key chord
    task automatic t_keys();
        for (int i = 0; i < 24; i++) begin
            req(1'b0);
            press_key(pos[i]);
            check("code", pos[i], code);
            check("value", 8'(i), {3'h0, val});
        end
        req(1'b0);
        press_key(8'h13);
        check("chord code", 8'h13, code);
        check("chord value", 8'h1f, {3'h0, val});
        $display("test keys done");
    endtask : t_keys
    // Closure gone before the recheck
    task automatic t_bounce();
        key = 8'h14;
        press = 1'b1;
        req(1'b0);
        repeat (4) @(negedge core_clk_i);
        press = 1'b0;
        wait_res(60);
        check("bounce no key", 8'h01, {7'h0, nk});
        $display("test bounce done");
    endtask : t_bounce
    // Translated read keeps polling until a key comes
    task automatic t_char();
        logic seen;
        seen = 1'b0;
        req(1'b1);
        repeat (100) begin
            @(negedge core_clk_i);
            seen = seen | kv | nk;
        end
        check("still polling", 8'h01, {7'h0, busy & !seen});
        // Chord with no table entry must not end a translated read
        key = 8'h13;
        press = 1'b1;
        repeat (40) @(negedge core_clk_i);
        press = 1'b0;
        repeat (40) begin
            @(negedge core_clk_i);
            seen = seen | kv | nk;
        end
        check("no table entry", 8'h01, {7'h0, busy & !seen});
        press_key(8'h51);
        check("char value", 8'h17, {3'h0, val});
        $display("test char done");
    endtask : t_char
    ////////////////////////////////////////////////////////////////////////////////
    // Clock, timeout and main sequence
    initial begin
        core_clk_i = 1'b0;
        forever #10 core_clk_i = ~core_clk_i;
    end
    // Hang guard
    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 6000) begin
            error_cnt++;
            results();
        end
    end
    initial begin
        pos = '{8'h11, 8'h21, 8'h22, 8'h24, 8'h31, 8'h32, 8'h34, 8'h41, 8'h42, 8'h44,
                8'h48, 8'h38, 8'h28, 8'h18, 8'h14, 8'h12, 8'h61, 8'h58, 8'h68, 8'h64,
                8'h62, 8'h54, 8'h52, 8'h51};
        error_cnt = 0;
        n_tests = 0;
        cyc = 0;
        scan_req = 1'b0;
        char_req = 1'b0;
        press = 1'b0;
        key = 8'h00;
        reset_n_i = 1'b0;
        repeat (4) @(negedge core_clk_i);
        reset_n_i = 1'b1;
        t_reset();
        t_nokey();
        t_keys();
        t_bounce();
        t_char();
        results();
    end
endmodule : keypad_matrix_scanner_test

// file: kms_debounce_timer.sv
`timescale 1ns/1ps
module kms_debounce_timer #(
    parameter int unsigned CYCLES = kms_pkg::DEBOUNCE_CYC
) (
    // Clock and reset
    input  wire logic core_clk_i,
    input  wire logic reset_n_i,
    // Control
    input  wire logic start_i,
    // Status
    output logic      done_o
);

    logic [kms_pkg::CNT_W-1:0] cnt_q;   // Remaining cycles
    logic                      run_q;   // Timer active

    wire logic last = run_q && (cnt_q == kms_pkg::CNT_W'(1));

    // Count down a fixed number of cycles, pulse done at the end
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            cnt_q  <= '0;
            run_q  <= 1'b0;
            done_o <= 1'b0;
        end else begin
            done_o <= last;
            if (start_i) begin
                cnt_q <= kms_pkg::CNT_W'(CYCLES);
                run_q <= 1'b1;
            end else if (run_q) begin
                cnt_q <= cnt_q - kms_pkg::CNT_W'(1);
                run_q <= !last;
            end
        end
    end

endmodule : kms_debounce_timer

// file: kms_keypad_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Passive key matrix behind the column decoder
module kms_keypad_model (
    // Column select from the scanner
    input  wire logic [7:0] port_i,
    // Key held by the bench
    input  wire logic       press_i,
    input  wire logic [7:0] key_i,
    // Row lines, pulled low when open
    output logic      [3:0] rows_o
);
    // Closed switch joins its column to its rows; open rows fall to 0
    assign rows_o = (press_i && port_i[6:4] == key_i[7:4]) ? key_i[3:0] : 4'h0;
endmodule : kms_keypad_model

// file: kms_pkg.sv
package kms_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Matrix geometry
    localparam int unsigned NUM_COLS      = 6;      // Column lines
    localparam int unsigned NUM_ROWS      = 4;      // Row lines
    localparam int unsigned SEL_W         = 3;      // Decoder select width
    localparam int unsigned SEL_LSB       = 4;      // Select sits on port bits 4..6
    localparam int unsigned PORT_W        = 8;      // Width of the scan port

    ////////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int unsigned CLK_HZ        = 50_000_000;  // Core clock rate
    localparam int unsigned DEBOUNCE_CYC  = 3075;        // Debounce length in bus cycles
    localparam int unsigned SETTLE_CYC    = 2;           // Row settle after column change
    localparam int unsigned CNT_W         = 12;          // Debounce counter width

    ////////////////////////////////////////////////////////////////////////////////
    // Codes
    localparam logic [7:0] NO_CODE        = 8'h00;  // No key seen
    localparam logic [4:0] NO_VALUE       = 5'h1f;  // Untranslatable code
    localparam logic [3:0] ROW_IDLE       = 4'h0;   // All rows open

    // Reported key
    typedef struct packed {
        logic [7:0] code;   // Column-row code
        logic [4:0] value;  // Translated value
    } kms_key_s;

endpackage : kms_pkg

// file: kms_scanner.sv
`timescale 1ns/1ps
// Contract
// - Column select drives port bits 4 to 6
// - Six columns, four rows sampled each
// - Keep polling columns while waiting
// - Debounce 3075 cycles after closure
// - Debounce length fixed in clock cycles
// - Debounce well below sixty milliseconds
// - Accept nonzero rows matching after debounce
// - Code is column high, rows low
// - Digit codes map to hex values
// - Command codes map to 10 to 17
// - Read request waits for valid key
module kms_scanner #(
    // Debounce length in core clocks; at 50 MHz the default lasts about 62 us,
    // far below any hold time a person would notice
    parameter int unsigned DEBOUNCE_CYC = kms_pkg::DEBOUNCE_CYC
) (
    // Clock and reset
    input  wire logic                   core_clk_i,
    input  wire logic                   reset_n_i,
    // Keypad port
    output logic [kms_pkg::PORT_W-1:0]  port_o,
    input  wire logic [kms_pkg::NUM_ROWS-1:0] rows_i,
    // Requester
    input  wire logic                   scan_for_key_i,
    input  wire logic                   read_translated_key_i,
    output logic                        busy_o,
    output logic                        key_valid_o,
    output logic                        no_key_o,
    output logic [7:0]                  key_code_o,
    output logic [4:0]                  key_value_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // Operation overview
    // A request taken in idle starts at column 1. Each column is driven for two
    // settle cycles and sampled once, so an empty column costs three cycles and
    // an empty pass about nineteen.
    // A nonzero row pattern starts the debounce timer. When it runs out the rows
    // are read again and must match the captured pattern exactly.
    // After a match the scanner waits for all rows to open, debounces the
    // release and looks once more, so a key that bounces as it is let go cannot
    // be reported twice.
    // A one-pass request ends in a key pulse or a no-key pulse. A translated read
    // never gives up: it wraps to column 1 after column 6, and also when the
    // accepted code has no table entry.
    // Requests that arrive while busy are ignored.
    // Limits: two keys in one column give a multi-bit row pattern with no table
    // entry; keys in two columns report the lower column. The debounce counter
    // is twelve bits wide, so DEBOUNCE_CYC must stay below 4096.

    ////////////////////////////////////////////////////////////////////////////////
    // States
    // Binary codes in scan order; unused codes fall back to idle
    // through the default branch
    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0000,  // Waiting for a request
        ST_SELECT = 4'b0001,  // Drive column, let rows settle
        ST_SAMPLE = 4'b0010,  // First row read
        ST_DEB1   = 4'b0011,  // Closure debounce
        ST_CHECK  = 4'b0100,  // Re-read after debounce
        ST_REL    = 4'b0101,  // Wait for release
        ST_DEB2   = 4'b0110,  // Release debounce
        ST_RELCHK = 4'b0111,  // Confirm release
        ST_XLATE  = 4'b1000,  // Lookup latency
        ST_DONE   = 4'b1001   // Report
    } kms_state_e;

    kms_state_e                 state_q;      // Current state
    kms_state_e                 state_d;      // Next state
    logic [2:0]                 col_q;        // Column index 1..6
    logic [2:0]                 col_d;
    logic [3:0]                 rows_q;       // Captured row pattern
    logic [3:0]                 rows_d;
    logic                       char_q;       // Translated read pending
    logic                       char_d;
    logic [1:0]                 settle_q;     // Row settle counter
    logic [1:0]                 settle_d;
    logic                       valid_d;
    logic                       nokey_d;
    logic [7:0]                 code_q;       // Accepted code
    logic [7:0]                 code_d;
    logic                       deb_start;    // Debounce kick
    logic                       deb_done;     // Debounce finished
    logic [4:0]                 xval;         // Looked-up value
    kms_pkg::kms_key_s          key_q;        // Reported key

    ////////////////////////////////////////////////////////////////////////////////
    // Decoding wires
    wire logic       rows_hit   = (rows_i != kms_pkg::ROW_IDLE);
    wire logic       rows_same  = (rows_i == rows_q);
    wire logic       last_col   = (col_q == 3'(kms_pkg::NUM_COLS));
    wire logic       settled    = (settle_q == 2'(kms_pkg::SETTLE_CYC - 1));
    wire logic       xlate_ok   = (xval != kms_pkg::NO_VALUE);
    wire logic [7:0] code_cat   = {1'b0, col_q, rows_q};
    // rows_same compares live rows with the captured pattern, so a second key
    // added during the debounce counts as a mismatch
    // Column put on the port: zero in idle so the decoder parks on an unused line
    wire logic [2:0] col_drive  = (state_d == ST_IDLE) ? 3'h0 : col_d;

    ////////////////////////////////////////////////////////////////////////////////
    // Debounce timer, fixed count of core cycles
    // Started only on entry to a debounce state, so a done pulse from one
    // debounce can never leak into the next
    kms_debounce_timer #(
        .CYCLES  (DEBOUNCE_CYC)
    ) u_debounce_wait (
        .core_clk_i (core_clk_i),
        .reset_n_i  (reset_n_i),
        .start_i    (deb_start),
        .done_o     (deb_done)
    );

    // Code translation table
    // Registered lookup; its output settles one edge after code_q
    kms_xlate u_code_translation_table (
        .core_clk_i (core_clk_i),
        .reset_n_i  (reset_n_i),
        .code_i     (code_q),
        .value_o    (xval)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    // Defaults hold every register, so a branch only names what it changes;
    // strobes default low and rise for one cycle in the branch that needs them
    always_comb begin
        state_d   = state_q;
        col_d     = col_q;
        rows_d    = rows_q;
        char_d    = char_q;
        settle_d  = settle_q;
        code_d    = code_q;
        deb_start = 1'b0;
        valid_d   = 1'b0;
        nokey_d   = 1'b0;
        case (state_q)
            // Accept a request
            // Translated mode wins when both requests are high
            ST_IDLE: begin
                if (scan_for_key_i || read_translated_key_i) begin
                    char_d   = read_translated_key_i;
                    col_d    = 3'h1;
                    settle_d = 2'h0;
                    state_d  = ST_SELECT;
                end
            end
            // Hold column while rows settle
            // Decoder and matrix need time after a column change
            ST_SELECT: begin
                settle_d = settle_q + 2'h1;
                if (settled) begin
                    state_d = ST_SAMPLE;
                end
            end
            // First read of the row lines
            ST_SAMPLE: begin
                if (rows_hit) begin
                    // Pattern kept for the recheck after the debounce
                    rows_d    = rows_i;
                    deb_start = 1'b1;
                    state_d   = ST_DEB1;
                end else if (last_col) begin
                    if (char_q) begin
                        col_d    = 3'h1;
                        settle_d = 2'h0;
                        state_d  = ST_SELECT;
                    end else begin
                        nokey_d = 1'b1;
                        state_d = ST_IDLE;
                    end
                end else begin
                    col_d    = col_q + 3'h1;
                    settle_d = 2'h0;
                    state_d  = ST_SELECT;
                end
            end
            // Wait out the closure bounce
            // Rows are ignored while the timer runs
            ST_DEB1: begin
                if (deb_done) begin
                    state_d = ST_CHECK;
                end
            end
            // Same pattern again means valid
            ST_CHECK: begin
                if (rows_same) begin
                    // Only an exact repeat of the first pattern is accepted
                    code_d  = code_cat;
                    state_d = ST_REL;
                end else if (last_col) begin
                    if (char_q) begin
                        col_d    = 3'h1;
                        settle_d = 2'h0;
                        state_d  = ST_SELECT;
                    end else begin
                        nokey_d = 1'b1;
                        state_d = ST_IDLE;
                    end
                end else begin
                    col_d    = col_q + 3'h1;
                    settle_d = 2'h0;
                    state_d  = ST_SELECT;
                end
            end
            // Wait for all rows open
            // A held key keeps the scanner busy for as long as it is held
            ST_REL: begin
                if (!rows_hit) begin
                    deb_start = 1'b1;
                    state_d   = ST_DEB2;
                end
            end
            // Wait out the release bounce
            // Rows are ignored here too until the timer ends
            ST_DEB2: begin
                if (deb_done) begin
                    state_d = ST_RELCHK;
                end
            end
            // Still open means done, else wait again
            // A release bounce sends the scan back to wait for open rows
            ST_RELCHK: begin
                state_d = rows_hit ? ST_REL : ST_XLATE;
            end
            // Allow the table register to load
            // The table registers its output, so give it an edge
            ST_XLATE: begin
                state_d = ST_DONE;
            end
            // Report or, for a translated read, retry on unknown code
            // An untranslatable code is dropped quietly in translated mode
            ST_DONE: begin
                if (char_q && !xlate_ok) begin
                    col_d    = 3'h1;
                    settle_d = 2'h0;
                    state_d  = ST_SELECT;
                end else begin
                    valid_d = 1'b1;
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State and datapath registers
    // All state moves together on one edge; reset parks the column
    // and empties the code register
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            state_q  <= ST_IDLE;
            col_q    <= 3'h0;
            rows_q   <= 4'h0;
            char_q   <= 1'b0;
            settle_q <= 2'h0;
            code_q   <= kms_pkg::NO_CODE;
        end else begin
            state_q  <= state_d;
            col_q    <= col_d;
            rows_q   <= rows_d;
            char_q   <= char_d;
            settle_q <= settle_d;
            code_q   <= code_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registered outputs
    // Every output comes from a flop so the keypad and requester never see
    // decode glitches. Code and value change only with a result pulse,
    // so a slow requester may read them at any later time.
    // Busy drops on the same edge as the result pulse.
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            port_o      <= '0;
            busy_o      <= 1'b0;
            key_valid_o <= 1'b0;
            no_key_o    <= 1'b0;
            key_q       <= '{code: kms_pkg::NO_CODE, value: kms_pkg::NO_VALUE};
        end else begin
            // Column select in bits 4..6, decoder does one-of-six
            port_o      <= {1'b0, col_drive, 4'h0};
            busy_o      <= (state_d != ST_IDLE);
            key_valid_o <= valid_d;
            no_key_o    <= nokey_d;
            if (valid_d) begin
                key_q <= '{code: code_q, value: xval};
            end else if (nokey_d) begin
                key_q <= '{code: kms_pkg::NO_CODE, value: kms_pkg::NO_VALUE};
            end
        end
    end

    assign key_code_o  = key_q.code;
    assign key_value_o = key_q.value;

endmodule : kms_scanner

// file: kms_scanner_properties.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Port checks for the key scanner
module kms_scanner_properties #(
    parameter int unsigned DEBOUNCE_CYC = kms_pkg::DEBOUNCE_CYC
) (
    // Clock and reset
    input wire logic       core_clk_i,
    input wire logic       reset_n_i,
    // Scanner ports
    input wire logic [7:0] port_o,
    input wire logic [3:0] rows_i,
    input wire logic       scan_for_key_i,
    input wire logic       read_translated_key_i,
    input wire logic       busy_o,
    input wire logic       key_valid_o,
    input wire logic       no_key_o,
    input wire logic [7:0] key_code_o,
    input wire logic [4:0] key_value_o
);
    logic [2:0]  col_q;   // Column seen last edge
    logic [11:0] stay_q;  // Edges the column held
    logic        step;    // Column moved between two live columns
    assign step = port_o[6:4] != col_q && col_q != 3'h0 && port_o[6:4] != 3'h0;
    // Track how long each column stands
    always_ff @(posedge core_clk_i) begin
        col_q  <= reset_n_i ? port_o[6:4] : 3'h0;
        stay_q <= (!reset_n_i || port_o[6:4] != col_q) ? 12'h0 : stay_q + 12'h1;
    end
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);
    chk_port_spare: assert property (
        port_o[7] == 1'b0 && port_o[3:0] == 4'h0) else $error("spare port bits set");
    chk_col_range: assert property (
        port_o[6:4] <= 3'h6) else $error("column index out of range");
    chk_col_order: assert property (
        step |-> port_o[6:4] == col_q + 3'h1 || (port_o[6:4] == 3'h1 && col_q == 3'h6))
        else $error("column order broken");
    chk_debounce_len: assert property (
        step |-> stay_q == 12'h2 || {20'h0, stay_q} >= DEBOUNCE_CYC + 32'd1)
        else $error("column left too early");
    chk_valid_code: assert property (
        key_valid_o |-> key_code_o[7:4] inside {[4'h1:4'h6]} && key_code_o[3:0] != 4'h0)
        else $error("bad key code");
    chk_nokey_code: assert property (
        no_key_o |-> key_code_o == kms_pkg::NO_CODE && key_value_o == kms_pkg::NO_VALUE)
        else $error("bad no-key result");
    chk_pulse_once: assert property (
        key_valid_o |=> !key_valid_o) else $error("key pulse too long");
    chk_busy_done: assert property (
        key_valid_o || no_key_o |-> !busy_o) else $error("busy after result");
    chk_release_seen: assert property (
        key_valid_o |-> $past(rows_i, 1) == 4'h0 && $past(rows_i, 2) == 4'h0)
        else $error("key reported before release");
    chk_code_hold: assert property (
        !(key_valid_o || no_key_o) |-> $stable(key_code_o)) else $error("code moved");
endmodule : kms_scanner_properties

bind kms_scanner kms_scanner_properties #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) u_props (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .port_o(port_o), .rows_i(rows_i),
    .scan_for_key_i(scan_for_key_i), .read_translated_key_i(read_translated_key_i),
    .busy_o(busy_o), .key_valid_o(key_valid_o), .no_key_o(no_key_o),
    .key_code_o(key_code_o), .key_value_o(key_value_o));

// file: kms_xlate.sv
`timescale 1ns/1ps
module kms_xlate (
    // Clock and reset
    input  wire logic       core_clk_i,
    input  wire logic       reset_n_i,
    // Code in
    input  wire logic [7:0] code_i,
    // Value out, registered
    output logic      [4:0] value_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // Code to value lookup
    function automatic logic [4:0] xlate(input logic [7:0] c);
        logic [4:0] v;
        v = kms_pkg::NO_VALUE;
        case (c)
            8'h11: v = 5'h00;
            8'h21: v = 5'h01;
            8'h22: v = 5'h02;
            8'h24: v = 5'h03;
            8'h31: v = 5'h04;
            8'h32: v = 5'h05;
            8'h34: v = 5'h06;
            8'h41: v = 5'h07;
            8'h42: v = 5'h08;
            8'h44: v = 5'h09;
            8'h48: v = 5'h0a;
            8'h38: v = 5'h0b;
            8'h28: v = 5'h0c;
            8'h18: v = 5'h0d;
            8'h14: v = 5'h0e;
            8'h12: v = 5'h0f;
            8'h61: v = 5'h10;  // Cancel key
            8'h58: v = 5'h11;  // Enter
            8'h68: v = 5'h12;  // Stack view key
            8'h64: v = 5'h13;
            8'h62: v = 5'h14;
            8'h54: v = 5'h15;
            8'h52: v = 5'h16;
            8'h51: v = 5'h17;
            default: v = kms_pkg::NO_VALUE;
        endcase
        return v;
    endfunction : xlate

    wire logic [4:0] value_d = xlate(code_i);  // Digits and commands

    // Register the lookup
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            value_o <= kms_pkg::NO_VALUE;
        end else begin
            value_o <= value_d;
        end
    end

endmodule : kms_xlate
